// ### ulpt_link_timers.sv
`timescale 1ns/1ns
`include "ulpt_defines.svh"

// How it works
// - Header-packet acknowledgment budget allows up to 10 us instead of 3 us.
// - When the acknowledgment budget runs out, the exchange is treated as failed.
// - Sending a low-power entry request runs the request-response timer.
// - Accepting a low-power entry request runs the entry timer.
// - Starting exit from U1 or U2 runs the exit timer.
// - All three power-management timeouts are longer than their legacy limits.
// - Suspended connected port, wake enabled, connect change uncleared: signal wake upstream.
// - Updated behaviour only on revision C silicon; older revisions stay legacy.
module ulpt_link_timers
   import ulpt_pkg::*;
#(
   parameter int unsigned CLK_NS    = `ULPT_CLK_PERIOD_NS,
   parameter int unsigned HP_LEG    = `ULPT_HP_LEG_NS / CLK_NS,
   parameter int unsigned HP_NEW    = `ULPT_HP_NEW_NS / CLK_NS,
   parameter int unsigned LC_LEG    = `ULPT_LC_LEG_NS / CLK_NS,
   parameter int unsigned LC_NEW    = `ULPT_LC_NEW_NS / CLK_NS,
   parameter int unsigned ENTRY_LEG = `ULPT_ENTRY_LEG_NS / CLK_NS,
   parameter int unsigned ENTRY_NEW = `ULPT_ENTRY_NEW_NS / CLK_NS,
   parameter int unsigned EXIT_LEG  = `ULPT_EXIT_LEG_NS / CLK_NS,
   parameter int unsigned EXIT_NEW  = `ULPT_EXIT_NEW_NS / CLK_NS
)
(
   input  wire logic i_ref_clk,
   input  wire logic i_nrst,
   input  wire logic i_rev_c,
   input  wire logic i_hp_sent,
   input  wire logic i_hp_ack,
   input  wire logic i_lpm_req_sent,
   input  wire logic i_lpm_resp,
   input  wire logic i_lpm_accept_sent,
   input  wire logic i_ux_entered,
   input  wire logic i_ux_exit_start,
   input  wire logic i_u0_reached,
   input  wire logic i_port_suspended,
   input  wire logic i_dev_connected,
   input  wire logic i_remote_wake_en,
   input  wire logic i_conn_change,
   output logic      o_rev_c_active,
   output logic      o_hp_pending,
   output logic      o_hp_timeout,
   output logic      o_lc_timeout,
   output logic      o_entry_timeout,
   output logic      o_exit_timeout,
   output logic      o_wake_req
);

   // Limits chosen once per build; the revision strap picks between them
   localparam ulpt_cnt_t HP_LEG_C    = ulpt_cnt_t'(HP_LEG);
   localparam ulpt_cnt_t HP_NEW_C    = ulpt_cnt_t'(HP_NEW);
   localparam ulpt_cnt_t LC_LEG_C    = ulpt_cnt_t'(LC_LEG);
   localparam ulpt_cnt_t LC_NEW_C    = ulpt_cnt_t'(LC_NEW);
   localparam ulpt_cnt_t ENTRY_LEG_C = ulpt_cnt_t'(ENTRY_LEG);
   localparam ulpt_cnt_t ENTRY_NEW_C = ulpt_cnt_t'(ENTRY_NEW);
   localparam ulpt_cnt_t EXIT_LEG_C  = ulpt_cnt_t'(EXIT_LEG);
   localparam ulpt_cnt_t EXIT_NEW_C  = ulpt_cnt_t'(EXIT_NEW);

   ulpt_top_s              s_r;
   ulpt_top_s              s_nxt;
   ulpt_cnt_t              lim     [`ULPT_NUM_T];
   logic [`ULPT_NUM_T-1:0] t_start;
   logic [`ULPT_NUM_T-1:0] t_stop;
   logic [`ULPT_NUM_T-1:0] t_busy;
   logic [`ULPT_NUM_T-1:0] t_exp;
   logic                   wake_cond;

   // =====================================================================
   // Timer selection and sequencing
   always_comb begin
      lim[`ULPT_T_HP]    = s_r.rev_c ? HP_NEW_C    : HP_LEG_C;
      lim[`ULPT_T_LC]    = s_r.rev_c ? LC_NEW_C    : LC_LEG_C;
      lim[`ULPT_T_ENTRY] = s_r.rev_c ? ENTRY_NEW_C : ENTRY_LEG_C;
      lim[`ULPT_T_EXIT]  = s_r.rev_c ? EXIT_NEW_C  : EXIT_LEG_C;
      t_start[`ULPT_T_HP]    = i_hp_sent;
      t_stop[`ULPT_T_HP]     = i_hp_ack;
      t_start[`ULPT_T_LC]    = i_lpm_req_sent;
      t_stop[`ULPT_T_LC]     = i_lpm_resp;
      t_start[`ULPT_T_ENTRY] = i_lpm_accept_sent;
      t_stop[`ULPT_T_ENTRY]  = i_ux_entered;
      t_start[`ULPT_T_EXIT]  = i_ux_exit_start;
      t_stop[`ULPT_T_EXIT]   = i_u0_reached;
   end

   genvar g;
   generate
      for (g = 0; g < `ULPT_NUM_T; g++) begin : g_tmr
         ulpt_timer u_tmr (
            .i_ref_clk (i_ref_clk),
            .i_nrst    (i_nrst),
            .i_start   (t_start[g]),
            .i_stop    (t_stop[g]),
            .i_limit   (lim[g]),
            .o_busy    (t_busy[g]),
            .o_expire  (t_exp[g])
         );
      end
   endgenerate

   // =====================================================================
   // State update
   assign wake_cond = i_port_suspended && i_dev_connected && i_remote_wake_en && i_conn_change;

   always_comb begin
      s_nxt        = s_r;
      s_nxt.rev_s1 = i_rev_c;
      s_nxt.rev_s2 = s_r.rev_s1;
      // Expiry becomes a failed-exchange pulse; the link layer must not go on
      s_nxt.tmo     = t_exp;
      s_nxt.hp_busy = t_busy[`ULPT_T_HP];
      s_nxt.cond_d  = wake_cond;
      // One wake pulse per new condition; legacy silicon stays quiet
      s_nxt.wake = s_r.rev_c && wake_cond && !s_r.cond_d;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         // Strap keeps shifting through both sync flops while reset is held,
         // so the settled pin is captured, then frozen for the session
         s_r.rev_s1  <= i_rev_c;
         s_r.rev_s2  <= s_r.rev_s1;
         s_r.rev_c   <= s_r.rev_s2;
         s_r.cond_d  <= 1'b0;
         s_r.wake    <= 1'b0;
         s_r.tmo     <= '0;
         s_r.hp_busy <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rev_c_active  = s_r.rev_c;
   assign o_hp_pending    = s_r.hp_busy;
   assign o_hp_timeout    = s_r.tmo[`ULPT_T_HP];
   assign o_lc_timeout    = s_r.tmo[`ULPT_T_LC];
   assign o_entry_timeout = s_r.tmo[`ULPT_T_ENTRY];
   assign o_exit_timeout  = s_r.tmo[`ULPT_T_EXIT];
   assign o_wake_req      = s_r.wake;

   // =====================================================================
   // Checks
   property p_hp_budget;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      s_r.rev_c |-> (lim[`ULPT_T_HP] == HP_NEW_C && HP_NEW_C > HP_LEG_C);
   endproperty
   a_hp_budget: assert property (p_hp_budget) else $error("turnaround budget not relaxed");

   property p_hp_fail;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      t_exp[`ULPT_T_HP] |=> (o_hp_timeout && !o_hp_pending) ##1 !o_hp_timeout;
   endproperty
   a_hp_fail: assert property (p_hp_fail) else $error("turnaround failure not flagged");

   property p_pm_extended;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      s_r.rev_c |-> (lim[`ULPT_T_LC] > LC_LEG_C && lim[`ULPT_T_ENTRY] > ENTRY_LEG_C
                     && lim[`ULPT_T_EXIT] > EXIT_LEG_C);
   endproperty
   a_pm_extended: assert property (p_pm_extended) else $error("pm timeout not extended");

   property p_wake;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (s_r.rev_c && wake_cond && !s_r.cond_d) |=> o_wake_req ##1 !o_wake_req;
   endproperty
   a_wake: assert property (p_wake) else $error("automatic wake missing");

   property p_legacy;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      !s_r.rev_c |-> (!o_wake_req && lim[`ULPT_T_HP] == HP_LEG_C
                      && lim[`ULPT_T_LC] == LC_LEG_C);
   endproperty
   a_legacy: assert property (p_legacy) else $error("legacy revision changed behaviour");

   property p_rev_stable;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      $stable(s_r.rev_c);
   endproperty
   a_rev_stable: assert property (p_rev_stable) else $error("revision changed after reset");

   property p_lc_fail;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      t_exp[`ULPT_T_LC] |=> o_lc_timeout ##1 !o_lc_timeout;
   endproperty
   a_lc_fail: assert property (p_lc_fail) else $error("request timeout missing");

   property p_entry_fail;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      t_exp[`ULPT_T_ENTRY] |=> o_entry_timeout ##1 !o_entry_timeout;
   endproperty
   a_entry_fail: assert property (p_entry_fail) else $error("entry timeout missing");

   property p_exit_fail;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      t_exp[`ULPT_T_EXIT] |=> o_exit_timeout ##1 !o_exit_timeout;
   endproperty
   a_exit_fail: assert property (p_exit_fail) else $error("exit timeout missing");

   property p_hp_pending;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      o_hp_pending == $past(t_busy[`ULPT_T_HP]);
   endproperty
   a_hp_pending: assert property (p_hp_pending) else $error("pending flag wrong");

   property p_wake_cause;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      o_wake_req |-> (s_r.rev_c && $past(wake_cond));
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("spurious wake");

   property p_wake_once;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      o_wake_req |=> !o_wake_req;
   endproperty
   a_wake_once: assert property (p_wake_once) else $error("wake pulse too long");

   property p_legacy_pm;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      !s_r.rev_c |-> (lim[`ULPT_T_ENTRY] == ENTRY_LEG_C && lim[`ULPT_T_EXIT] == EXIT_LEG_C);
   endproperty
   a_legacy_pm: assert property (p_legacy_pm) else $error("legacy pm limit changed");

endmodule

// ### ulpt_defines.svh
`ifndef ULPT_DEFINES_SVH
`define ULPT_DEFINES_SVH

// =====================================================================
// Clock
`define ULPT_CLK_PERIOD_NS    4
`define ULPT_CNT_W            16

// =====================================================================
// Header-packet acknowledgment turnaround budget
`define ULPT_HP_LEG_NS        3000
`define ULPT_HP_NEW_NS        10000

// =====================================================================
// Link power-management timeouts (build-time defaults)
`define ULPT_LC_LEG_NS        3000
`define ULPT_LC_NEW_NS        10000
`define ULPT_ENTRY_LEG_NS     6000
`define ULPT_ENTRY_NEW_NS     12000
`define ULPT_EXIT_LEG_NS      6000
`define ULPT_EXIT_NEW_NS      12000

// =====================================================================
// Timer indices
`define ULPT_T_HP             0
`define ULPT_T_LC             1
`define ULPT_T_ENTRY          2
`define ULPT_T_EXIT           3
`define ULPT_NUM_T            4

`endif

// ### ulpt_pkg.sv
`include "ulpt_defines.svh"

package ulpt_pkg;

   typedef enum logic [1:0] {
      ULPT_TMR_IDLE = 2'b01,
      ULPT_TMR_RUN  = 2'b10
   } ulpt_tmr_e;

   typedef logic [`ULPT_CNT_W-1:0] ulpt_cnt_t;

   typedef struct packed {
      ulpt_tmr_e st;
      ulpt_cnt_t cnt;
      logic      exp;
   } ulpt_tmr_s;

   typedef struct packed {
      logic                  rev_s1;
      logic                  rev_s2;
      logic                  rev_c;
      logic                  cond_d;
      logic                  wake;
      logic [`ULPT_NUM_T-1:0] tmo;
      logic                  hp_busy;
   } ulpt_top_s;

endpackage

// ### ulpt_timer.sv
`timescale 1ns/1ns
`include "ulpt_defines.svh"

module ulpt_timer
   import ulpt_pkg::*;
(
   input  wire logic      i_ref_clk,
   input  wire logic      i_nrst,
   input  wire logic      i_start,
   input  wire logic      i_stop,
   input  wire ulpt_cnt_t i_limit,
   output logic           o_busy,
   output logic           o_expire
);

   ulpt_tmr_s s_r;
   ulpt_tmr_s s_nxt;

   // =====================================================================
   // Watchdog: while running, stop wins over start and a start restarts; in idle a start wins
   always_comb begin
      s_nxt     = s_r;
      s_nxt.exp = 1'b0;
      case (s_r.st)
         ULPT_TMR_IDLE: begin
            if (i_start) begin
               s_nxt.st  = ULPT_TMR_RUN;
               s_nxt.cnt = '0;
            end
         end
         ULPT_TMR_RUN: begin
            if (i_stop) begin
               s_nxt.st = ULPT_TMR_IDLE;
            end else if (i_start) begin
               s_nxt.cnt = '0;
            end else if (s_r.cnt == i_limit - ulpt_cnt_t'(1)) begin
               s_nxt.st  = ULPT_TMR_IDLE;
               s_nxt.exp = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt + ulpt_cnt_t'(1);
            end
         end
         default: begin
            s_nxt.st = ULPT_TMR_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         s_r.st  <= ULPT_TMR_IDLE;
         s_r.cnt <= '0;
         s_r.exp <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_busy   = (s_r.st == ULPT_TMR_RUN);
   assign o_expire = s_r.exp;

   // =====================================================================
   // Checks
   property p_tmr_start;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (s_r.st == ULPT_TMR_IDLE && i_start) |=> (o_busy && s_r.cnt == '0);
   endproperty
   a_tmr_start: assert property (p_tmr_start) else $error("timer did not start");

   property p_tmr_bound;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      o_busy |-> (s_r.cnt < i_limit);
   endproperty
   a_tmr_bound: assert property (p_tmr_bound) else $error("timer ran past limit");

   property p_tmr_fire;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (o_busy && !i_stop && !i_start && s_r.cnt == i_limit - ulpt_cnt_t'(1))
         |=> (o_expire && !o_busy) ##1 !o_expire;
   endproperty
   a_tmr_fire: assert property (p_tmr_fire) else $error("timer expiry wrong");

   property p_tmr_stop;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (o_busy && i_stop) |=> (!o_busy && !o_expire);
   endproperty
   a_tmr_stop: assert property (p_tmr_stop) else $error("stopped timer fired");

endmodule

// ### ulpt_partner.sv
`timescale 1ns/1ns

// =====================================================================
// Link partner: answers each started exchange after i_dly cycles when i_dly is nonzero
module ulpt_partner (
   input  wire logic       i_ref_clk,
   input  wire logic       i_nrst,
   input  wire logic [3:0] i_req,
   input  wire logic [7:0] i_dly,
   output logic      [3:0] o_ans
);
   logic [7:0] cnt_r [4];

   always_ff @(posedge i_ref_clk) begin
      for (int k = 0; k < 4; k++) begin
         o_ans[k] <= 1'b0;
         if (!i_nrst) begin
            cnt_r[k] <= 8'h00;
         end else if (i_req[k]) begin
            // Zero delay means a partner that stays silent, so the budget runs out
            cnt_r[k] <= i_dly;
         end else if (cnt_r[k] == 8'h01) begin
            o_ans[k] <= 1'b1;
            cnt_r[k] <= 8'h00;
         end else if (cnt_r[k] != 8'h00) begin
            cnt_r[k] <= cnt_r[k] - 8'h01;
         end
      end
   end
endmodule

// ### tb_ulpt_link_timers.sv
`timescale 1ns/1ns

module tb_ulpt_link_timers;
   import ulpt_pkg::*;
   // A slow nominal clock scales all limits down: legacy HP, LC, ENTRY, EXIT, then new
   localparam int unsigned LIM [8] = '{3, 3, 6, 6, 10, 10, 12, 12};
   logic       i_ref_clk = 1'b0;
   logic       i_nrst    = 1'b0;
   logic       i_rev_c   = 1'b0;
   logic [3:0] start     = 4'h0;
   logic [3:0] stop;
   logic [7:0] dly       = 8'h00;
   logic [3:0] status    = 4'h0;
   logic [3:0] tmo;
   logic       o_rev_c_active;
   logic       o_hp_pending;
   logic       o_wake_req;
   int         num_errors   = 0;
   int         total_checks = 0;

   always #2 i_ref_clk = ~i_ref_clk;

   ulpt_link_timers #(.CLK_NS(1000)) u_dut (
      .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_rev_c(i_rev_c),
      .i_hp_sent(start[0]), .i_hp_ack(stop[0]),
      .i_lpm_req_sent(start[1]), .i_lpm_resp(stop[1]),
      .i_lpm_accept_sent(start[2]), .i_ux_entered(stop[2]),
      .i_ux_exit_start(start[3]), .i_u0_reached(stop[3]),
      .i_port_suspended(status[3]), .i_dev_connected(status[2]),
      .i_remote_wake_en(status[1]), .i_conn_change(status[0]),
      .o_rev_c_active(o_rev_c_active), .o_hp_pending(o_hp_pending),
      .o_hp_timeout(tmo[0]), .o_lc_timeout(tmo[1]), .o_entry_timeout(tmo[2]),
      .o_exit_timeout(tmo[3]), .o_wake_req(o_wake_req));

   ulpt_partner u_partner (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_req(start),
      .i_dly(dly), .o_ans(stop));

   // =====================================================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Strap needs more than two edges to pass the sync flops
   task automatic do_reset(input logic rev);
      i_nrst = 1'b0;
      i_rev_c = rev;
      status = 4'h0;
      repeat (4) @(negedge i_ref_clk);
      i_nrst = 1'b1;
      check(16'(o_rev_c_active), 16'(rev));
   endtask

   // Returns the edge count from start to the timeout pulse, 0 if none
   task automatic fire(input int k, input logic [7:0] d, output int n);
      dly = d;
      start[k] = 1'b1;
      @(negedge i_ref_clk);
      start[k] = 1'b0;
      n = 0;
      for (int c = 1; c < 40 && n == 0; c++) begin
         @(posedge i_ref_clk);
         #1;
         if (tmo[k] === 1'b1) n = c;
      end
      repeat (4) @(negedge i_ref_clk);
   endtask

   task automatic watch_wake(output int first, output int num);
      first = 0;
      num = 0;
      for (int c = 1; c <= 8; c++) begin
         @(posedge i_ref_clk);
         #1;
         if (o_wake_req === 1'b1) begin
            num++;
            if (first == 0) first = c;
         end
      end
      @(negedge i_ref_clk);
   endtask

   // =====================================================================
   // Scenarios
   task automatic test_timers(input logic rev);
      int n;
      do_reset(rev);
      for (int k = 0; k < 4; k++) begin
         fire(k, 8'h00, n);
         check(16'(n), 16'(LIM[k + 4 * int'(rev)] + 1));
         fire(k, 8'h02, n);
         check(16'(n), 16'h0000);
      end
      $display("test_timers rev=%0d done", rev);
   endtask

   task automatic test_restart;
      int n;
      // Silent partner, so only the restart decides when the budget ends
      dly = 8'h00;
      start[0] = 1'b1;
      @(negedge i_ref_clk);
      start[0] = 1'b0;
      repeat (2) @(negedge i_ref_clk);
      check(16'(o_hp_pending), 16'h0001);
      fire(0, 8'h00, n);
      check(16'(n), 16'(LIM[4] + 1));
      check(16'(o_hp_pending), 16'h0000);
      $display("test_restart done");
   endtask

   task automatic test_wake(input logic rev);
      int f;
      int m;
      do_reset(rev);
      status = 4'b1110;
      watch_wake(f, m);
      check(16'(m), 16'h0000);
      status = 4'hf;
      watch_wake(f, m);
      check(16'(f), rev ? 16'h0001 : 16'h0000);
      check(16'(m), 16'(rev));
      status = 4'b1011;
      watch_wake(f, m);
      check(16'(m), 16'h0000);
      status = 4'b1101;
      watch_wake(f, m);
      check(16'(m), 16'h0000);
      status = 4'b0111;
      watch_wake(f, m);
      check(16'(m), 16'h0000);
      status = 4'hf;
      watch_wake(f, m);
      check(16'(m), 16'(rev));
      $display("test_wake rev=%0d done", rev);
   endtask

   initial begin
      test_timers(1'b0);
      test_timers(1'b1);
      test_restart();
      test_wake(1'b1);
      test_wake(1'b0);
      finish_test();
   end
endmodule
